// ===== pkg/request_intake_consts.vh
// Constants for the outbound request channel intake: register map,
// sideband field positions, request kinds and reset values.
// Assumes inclusion by bare name from the rtl files.
`ifndef REQUEST_INTAKE_CONSTS_VH
`define REQUEST_INTAKE_CONSTS_VH

// Register byte offsets on the APB slave
`define OFS_CONTROL 8'h00
`define OFS_STATUS 8'h04
`define OFS_TABLE_INDEX 8'h08
`define OFS_TABLE_DATA 8'h0c
`define OFS_PACKET_COUNT 8'h10

// Reset values
`define RST_CONTROL 1'b0
`define RST_TABLE_INDEX 8'h00

// Control register fields
`define CTL_HINT_ENABLE 0

// Sideband bus layout
`define SB_WIDTH 23
`define SB_HEAD_BE_LSB 0
`define SB_TAIL_BE_LSB 4
`define SB_OFFSET_LSB 8
`define SB_HINT_PRESENT 11
`define SB_HINT_INDIRECT 12
`define SB_STEER_LSB 13
`define SB_KIND_LSB 21

// Descriptor field positions
`define DESC_AT_MSB 1
`define DESC_ADDR_MSB 63
`define DESC_ADDR_LSB 2
`define DESC_COUNT_MSB 74
`define DESC_COUNT_LSB 64
`define DESC_TYPE_MSB 78
`define DESC_TYPE_LSB 75

// Request kinds
`define REQ_MEM_READ 4'h0
`define REQ_MEM_WRITE 4'h1
`define REQ_IO_READ 4'h2
`define REQ_IO_WRITE 4'h3
`define REQ_ATOMIC_ADD 4'h4
`define REQ_ATOMIC_SWAP 4'h5
`define REQ_ATOMIC_CAS 4'h6
`define REQ_MEM_LOCKED_READ 4'h7
`define REQ_CFG0_READ 4'h8
`define REQ_CFG0_WRITE 4'h9
`define REQ_CFG1_READ 4'ha
`define REQ_CFG1_WRITE 4'hb
`define REQ_MESSAGE 4'hc
`define REQ_VENDOR_MESSAGE 4'hd
`define REQ_ATS_MESSAGE 4'he

// Descriptor layouts
`define LAYOUT_MEM_IO_ATOMIC 3'h0
`define LAYOUT_CONFIG 3'h1
`define LAYOUT_VENDOR 3'h2
`define LAYOUT_ATS 3'h3
`define LAYOUT_OTHER_MSG 3'h4

// Address type encodings
`define AT_UNTRANSLATED 2'h0
`define AT_RESERVED 2'h3

// Dword lane where payload follows the descriptor in one wide beat
`define DESC_END_LANE 3'h4

`endif

// ===== rtl/steer_table.v
// Steering tag table, one byte per entry, one write and one read port.
// Assumes a single clock; read data appear one edge after the address.
`timescale 1ns/10ps
module steer_table #(
   parameter ENTRIES = 256,
   parameter AW = 8
) (
   input wire ref_clk,
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [7:0] wr_data,
   input wire [AW-1:0] rd_addr,
   output reg [7:0] rd_data
);
   reg [7:0] mem [0:ENTRIES-1];

   // No reset: software loads it before use
   always @(posedge ref_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule

// ===== rtl/sync_fifo.v
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; depth is a power of two.
`timescale 1ns/10ps
module sync_fifo #(
   parameter WIDTH = 33,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire ref_clk,
   input wire reset,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;

   assign in_ready = (count != DEPTH[AW:0]);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always @(posedge ref_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push & ~pop) begin
            count <= count + 1'b1;
         end else if (pop & ~push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

// ===== rtl/request_intake.v
// Outbound request channel intake: takes client request packets off a
// stream, splits descriptor from payload and presents header fields plus
// a Dword payload stream. APB slave holds control and steering table.
// Assumes stream and APB run on ref_clk; no synchronisers needed.
`timescale 1ns/10ps
`include "request_intake_consts.vh"

// How it works
// - Payload placement follows the build-time alignment mode parameter.
// - Address mode: sideband offset gives the first payload lane.
// - Indirect hint: steering value read from the table at the index.
// - Descriptor spans two beats at 64 bits, one beat when wider.
// - Request kind selects one of five descriptor layouts.
// - Address type bits 1:0 apply to memory and atomic requests only.
// - Address type is copied unchanged into the outgoing header.
// - Dword count is never checked against payload or size limits.
module request_intake #(
   parameter DATA_WIDTH = 128,
   parameter payload_alignment_select = 0,
   parameter FIFO_DEPTH = 8,
   parameter FIFO_AW = 3
) (
   input wire ref_clk,
   input wire reset,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire [DATA_WIDTH-1:0] req_tdata,
   input wire [DATA_WIDTH/32-1:0] req_tkeep,
   input wire req_tvalid,
   input wire req_tlast,
   output reg req_tready,
   input wire [`SB_WIDTH-1:0] request_sideband_bus,
   output reg hdr_valid,
   input wire hdr_ready,
   output reg [2:0] hdr_layout,
   output reg [3:0] hdr_request_type,
   output reg [1:0] hdr_address_type,
   output reg [63:2] hdr_address,
   output reg [10:0] hdr_dword_count,
   output reg [3:0] head_dword_byte_enables,
   output reg [3:0] tail_dword_byte_enables,
   output reg hdr_hint_present,
   output reg [7:0] hint_steering_value,
   output reg [1:0] hint_steering_kind,
   output wire pay_valid,
   input wire pay_ready,
   output wire [31:0] pay_data,
   output wire pay_last
);
   localparam LANES = DATA_WIDTH / 32;
   localparam ST_DESC = 3'h0;
   localparam ST_DESC_HI = 3'h1;
   localparam ST_LOOKUP = 3'h2;
   localparam ST_FETCH = 3'h3;
   localparam ST_UNPACK = 3'h4;

   reg [2:0] state;
   reg [2:0] next_state;
   reg [127:0] desc;
   reg [`SB_WIDTH-1:0] sb;
   reg pkt_done;
   reg [255:0] beat;
   reg [7:0] beat_keep;
   reg beat_last;
   reg beat_held;
   reg [2:0] lane;
   reg hint_enable;
   reg [7:0] table_index;
   reg [7:0] table_data;
   reg [31:0] packet_count;
   reg [255:0] tdata_wide;
   reg [7:0] tkeep_wide;
   reg push_valid;
   wire push_ready;
   wire [7:0] table_rd_data;
   wire [7:0] table_rd_addr;
   wire beat_take;
   wire lane_kept;
   wire lane_final;
   wire apb_write;
   wire apb_setup;
   wire [3:0] req_kind;

   function [2:0] layout_of;
      input [3:0] kind;
      begin
         case (kind)
            `REQ_CFG0_READ, `REQ_CFG0_WRITE, `REQ_CFG1_READ, `REQ_CFG1_WRITE: layout_of = `LAYOUT_CONFIG;
            `REQ_VENDOR_MESSAGE: layout_of = `LAYOUT_VENDOR;
            `REQ_ATS_MESSAGE: layout_of = `LAYOUT_ATS;
            `REQ_MESSAGE: layout_of = `LAYOUT_OTHER_MSG;
            default: layout_of = `LAYOUT_MEM_IO_ATOMIC;
         endcase
      end
   endfunction

   // Memory and atomic kinds carry an address type; I/O does not
   function is_mem_or_atomic;
      input [3:0] kind;
      begin
         is_mem_or_atomic = (layout_of(kind) == `LAYOUT_MEM_IO_ATOMIC) &&
                            (kind != `REQ_IO_READ) && (kind != `REQ_IO_WRITE);
      end
   endfunction

   // True when no kept lane sits above the given one
   function none_above;
      input [7:0] keep;
      input [2:0] idx;
      integer i;
      begin
         none_above = 1'b1;
         for (i = 0; i < 8; i = i + 1) begin
            if ((i > idx) && keep[i]) begin
               none_above = 1'b0;
            end
         end
      end
   endfunction

   always @* begin
      tdata_wide = 256'h0;
      tdata_wide[DATA_WIDTH-1:0] = req_tdata;
      tkeep_wide = 8'h00;
      tkeep_wide[LANES-1:0] = req_tkeep;
   end

   assign req_kind = desc[`DESC_TYPE_MSB:`DESC_TYPE_LSB];
   assign beat_take = req_tvalid & req_tready;
   assign lane_kept = beat_keep[lane];
   assign lane_final = (lane == LANES - 1) || none_above(beat_keep, lane);

   // Index taken live so the table answers in time
   assign table_rd_addr = (state == ST_DESC) ? request_sideband_bus[`SB_STEER_LSB+:8] : sb[`SB_STEER_LSB+:8];

   always @* begin
      req_tready = 1'b0;
      push_valid = 1'b0;
      next_state = state;
      case (state)
         ST_DESC: begin
            // New header held off until the previous one is taken
            req_tready = ~hdr_valid;
            if (beat_take) begin
               next_state = (DATA_WIDTH == 64) ? ST_DESC_HI : ST_LOOKUP;
            end
         end
         ST_DESC_HI: begin
            req_tready = 1'b1;
            if (beat_take) begin
               next_state = ST_LOOKUP;
            end
         end
         ST_LOOKUP: begin
            if (pkt_done) begin
               next_state = ST_DESC;
            end else if (beat_held) begin
               next_state = ST_UNPACK;
            end else begin
               next_state = ST_FETCH;
            end
         end
         ST_FETCH: begin
            req_tready = 1'b1;
            if (beat_take) begin
               next_state = ST_UNPACK;
            end
         end
         ST_UNPACK: begin
            push_valid = lane_kept;
            if ((~lane_kept | push_ready) && lane_final) begin
               next_state = beat_last ? ST_DESC : ST_FETCH;
            end
         end
         default: next_state = ST_DESC;
      endcase
   end

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state <= ST_DESC;
         desc <= 128'h0;
         sb <= {`SB_WIDTH{1'b0}};
         pkt_done <= 1'b0;
         beat <= 256'h0;
         beat_keep <= 8'h00;
         beat_last <= 1'b0;
         beat_held <= 1'b0;
         lane <= 3'h0;
      end else begin
         state <= next_state;
         case (state)
            ST_DESC: begin
               if (beat_take) begin
                  // Sideband of the first beat carries hints and enables
                  sb <= request_sideband_bus;
                  pkt_done <= req_tlast;
                  beat_held <= 1'b0;
                  if (DATA_WIDTH == 64) begin
                     desc[63:0] <= tdata_wide[63:0];
                  end else begin
                     desc <= tdata_wide[127:0];
                  end
                  // Wide beat in dword mode already holds payload lanes
                  if (DATA_WIDTH == 256 && payload_alignment_select == 0 && !req_tlast) begin
                     beat <= tdata_wide;
                     beat_keep <= tkeep_wide;
                     beat_last <= 1'b0;
                     beat_held <= 1'b1;
                     lane <= `DESC_END_LANE;
                  end
               end
            end
            ST_DESC_HI: begin
               if (beat_take) begin
                  desc[127:64] <= tdata_wide[63:0];
                  pkt_done <= req_tlast;
               end
            end
            ST_FETCH: begin
               if (beat_take) begin
                  beat <= tdata_wide;
                  beat_keep <= tkeep_wide;
                  beat_last <= req_tlast;
                  beat_held <= 1'b0;
                  // First payload beat: address mode starts at the given lane
                  if (beat_held == 1'b0 && payload_alignment_select != 0 && lane == 3'h0) begin
                     lane <= sb[`SB_OFFSET_LSB+:3] & (LANES[2:0] - 3'h1);
                  end else begin
                     lane <= 3'h0;
                  end
               end
            end
            ST_UNPACK: begin
               if (~lane_kept | push_ready) begin
                  if (lane_final) begin
                     lane <= 3'h7;
                     beat_held <= 1'b1;
                  end else begin
                     lane <= lane + 3'h1;
                  end
               end
            end
            ST_LOOKUP: begin
               if (!beat_held) begin
                  lane <= 3'h0;
               end
            end
            default: lane <= lane;
         endcase
      end
   end

   // Header fields; count, and the address of the memory, I/O and atomic layout, pass untouched, no range checks
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         hdr_valid <= 1'b0;
         hdr_layout <= `LAYOUT_MEM_IO_ATOMIC;
         hdr_request_type <= 4'h0;
         hdr_address_type <= `AT_UNTRANSLATED;
         hdr_address <= 62'h0;
         hdr_dword_count <= 11'h000;
         head_dword_byte_enables <= 4'h0;
         tail_dword_byte_enables <= 4'h0;
         hdr_hint_present <= 1'b0;
         hint_steering_value <= 8'h00;
         hint_steering_kind <= 2'h0;
         packet_count <= 32'h0;
      end else begin
         if (hdr_valid && hdr_ready) begin
            hdr_valid <= 1'b0;
         end
         if (state == ST_LOOKUP) begin
            hdr_valid <= 1'b1;
            packet_count <= packet_count + 32'h1;
            hdr_layout <= layout_of(req_kind);
            hdr_request_type <= req_kind;
            hdr_address_type <= is_mem_or_atomic(req_kind) ? desc[`DESC_AT_MSB:0] : `AT_UNTRANSLATED;
            hdr_address <= (layout_of(req_kind) == `LAYOUT_MEM_IO_ATOMIC) ?
                           desc[`DESC_ADDR_MSB:`DESC_ADDR_LSB] : 62'h0;
            hdr_dword_count <= desc[`DESC_COUNT_MSB:`DESC_COUNT_LSB];
            head_dword_byte_enables <= sb[`SB_HEAD_BE_LSB+:4];
            tail_dword_byte_enables <= sb[`SB_TAIL_BE_LSB+:4];
            hdr_hint_present <= hint_enable & sb[`SB_HINT_PRESENT];
            hint_steering_kind <= sb[`SB_KIND_LSB+:2];
            hint_steering_value <= sb[`SB_HINT_INDIRECT] ? table_rd_data : sb[`SB_STEER_LSB+:8];
         end
      end
   end

   steer_table #(
      .ENTRIES(256),
      .AW(8)
   ) u_table (
      .ref_clk(ref_clk),
      .wr_en(apb_write && paddr == `OFS_TABLE_DATA),
      .wr_addr(table_index),
      .wr_data(pwdata[7:0]),
      .rd_addr(table_rd_addr),
      .rd_data(table_rd_data)
   );

   // Stalling here throttles the stream when the drain side stops
   sync_fifo #(
      .WIDTH(33),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .ref_clk(ref_clk),
      .reset(reset),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data({beat_last & lane_final, beat[lane*32+:32]}),
      .out_valid(pay_valid),
      .out_ready(pay_ready),
      .out_data({pay_last, pay_data})
   );

   // APB slave: zero wait states, error on unmapped offsets
   assign apb_setup = psel & ~penable;
   assign apb_write = psel & penable & pwrite;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~(paddr == `OFS_CONTROL || paddr == `OFS_STATUS ||
                    paddr == `OFS_TABLE_INDEX || paddr == `OFS_TABLE_DATA || paddr == `OFS_PACKET_COUNT);

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         hint_enable <= `RST_CONTROL;
         table_index <= `RST_TABLE_INDEX;
         table_data <= 8'h00;
         prdata <= 32'h0;
      end else begin
         if (apb_write) begin
            case (paddr)
               `OFS_CONTROL: hint_enable <= pwdata[`CTL_HINT_ENABLE];
               `OFS_TABLE_INDEX: table_index <= pwdata[7:0];
               `OFS_TABLE_DATA: table_data <= pwdata[7:0];
               default: hint_enable <= hint_enable;
            endcase
         end
         if (apb_setup) begin
            case (paddr)
               `OFS_CONTROL: prdata <= {31'h0, hint_enable};
               `OFS_STATUS: prdata <= {26'h0, pay_valid, ~push_ready, state, hdr_valid};
               `OFS_TABLE_INDEX: prdata <= {24'h0, table_index};
               `OFS_TABLE_DATA: prdata <= {24'h0, table_data};
               `OFS_PACKET_COUNT: prdata <= packet_count;
               default: prdata <= 32'h0;
            endcase
         end
      end
   end
endmodule

// ===== testbench/request_intake_monitor.sv
// Checker on the intake's stream, header and payload ports.
// Assumes a bind to request_intake, 128-bit datapath, dword mode.
`timescale 1ns/10ps
`include "request_intake_consts.vh"
module request_intake_monitor #(
   parameter DATA_WIDTH = 128
) (
   input wire ref_clk,
   input wire reset,
   input wire [DATA_WIDTH-1:0] req_tdata,
   input wire req_tvalid,
   input wire req_tlast,
   input wire req_tready,
   input wire [`SB_WIDTH-1:0] request_sideband_bus,
   input wire hdr_valid,
   input wire hdr_ready,
   input wire [1:0] hdr_address_type,
   input wire [63:2] hdr_address,
   input wire [10:0] hdr_dword_count,
   input wire [3:0] head_dword_byte_enables,
   input wire pay_valid,
   input wire pay_ready,
   input wire [31:0] pay_data
);
   reg in_pkt;
   wire first_beat = req_tvalid && req_tready && !in_pkt;
   wire [3:0] kind = req_tdata[78:75];
   wire mem_kind = kind < 4'h8 && kind != `REQ_IO_READ && kind != `REQ_IO_WRITE;
   // Tracks packet boundaries so the descriptor beat can be told apart
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         in_pkt <= 1'b0;
      end else if (req_tvalid && req_tready) begin
         in_pkt <= !req_tlast;
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   property p_lookup;
      first_beat |=> !req_tready ##1 hdr_valid;
   endproperty
   a_lookup: assert property (p_lookup) else $error("descriptor not followed by lookup");
   property p_at_copy;
      first_beat && mem_kind |-> ##2 hdr_address_type == $past(req_tdata[1:0], 2);
   endproperty
   a_at_copy: assert property (p_at_copy) else $error("address type not copied");
   property p_at_other;
      first_beat && !mem_kind |-> ##2 hdr_address_type == 2'h0;
   endproperty
   a_at_other: assert property (p_at_other) else $error("address type on non memory request");
   property p_count;
      first_beat |-> ##2 hdr_dword_count == $past(req_tdata[74:64], 2);
   endproperty
   a_count: assert property (p_count) else $error("dword count altered");
   property p_addr;
      first_beat && kind < 4'h8 |-> ##2 hdr_address == $past(req_tdata[63:2], 2);
   endproperty
   a_addr: assert property (p_addr) else $error("address altered");
   property p_be;
      first_beat |-> ##2 head_dword_byte_enables == $past(request_sideband_bus[3:0], 2);
   endproperty
   a_be: assert property (p_be) else $error("head byte enables altered");
   property p_hdr_hold;
      hdr_valid && !hdr_ready |=> hdr_valid && $stable(hdr_address) && $stable(hdr_dword_count);
   endproperty
   a_hdr_hold: assert property (p_hdr_hold) else $error("header dropped before taken");
   property p_refuse;
      hdr_valid && !in_pkt |-> !req_tready;
   endproperty
   a_refuse: assert property (p_refuse) else $error("new descriptor taken over pending header");
   property p_pay_hold;
      pay_valid && !pay_ready |=> pay_valid && $stable(pay_data);
   endproperty
   a_pay_hold: assert property (p_pay_hold) else $error("payload word changed while stalled");
   c_hdr_only: cover property (first_beat && req_tlast);
   c_stall: cover property (pay_valid && !pay_ready ##1 pay_valid);
   c_refused: cover property (req_tvalid && !req_tready);
endmodule
bind request_intake request_intake_monitor #(.DATA_WIDTH(DATA_WIDTH)) mon_u (
   .ref_clk(ref_clk),
   .reset(reset),
   .req_tdata(req_tdata),
   .req_tvalid(req_tvalid),
   .req_tlast(req_tlast),
   .req_tready(req_tready),
   .request_sideband_bus(request_sideband_bus),
   .hdr_valid(hdr_valid),
   .hdr_ready(hdr_ready),
   .hdr_address_type(hdr_address_type),
   .hdr_address(hdr_address),
   .hdr_dword_count(hdr_dword_count),
   .head_dword_byte_enables(head_dword_byte_enables),
   .pay_valid(pay_valid),
   .pay_ready(pay_ready),
   .pay_data(pay_data)
);

// ===== testbench/client_model.sv
// Client model: sends request packets on the 128-bit stream.
// Assumes tasks are called just after a rising edge of ref_clk.
`timescale 1ns/10ps
`include "request_intake_consts.vh"
module client_model (
   input wire ref_clk,
   input wire req_tready,
   output reg [127:0] req_tdata,
   output reg [3:0] req_tkeep,
   output reg req_tvalid,
   output reg req_tlast,
   output reg [`SB_WIDTH-1:0] request_sideband_bus
);
   initial begin
      req_tdata = 128'h0;
      req_tkeep = 4'h0;
      req_tvalid = 1'b0;
      req_tlast = 1'b0;
      request_sideband_bus = 'h0;
   end
   // Released lines flip, never stale
   task idle;
      req_tvalid <= 1'b0;
      req_tdata <= ~req_tdata;
      req_tkeep <= ~req_tkeep;
      req_tlast <= ~req_tlast;
      request_sideband_bus <= ~request_sideband_bus;
   endtask
   task beat(input [127:0] d, input [3:0] k, input l, input [`SB_WIDTH-1:0] sb);
      req_tdata <= d;
      req_tkeep <= k;
      req_tlast <= l;
      request_sideband_bus <= sb;
      req_tvalid <= 1'b1;
      @(posedge ref_clk);
      while (req_tready !== 1'b1) @(posedge ref_clk);
   endtask
   task send(input [127:0] d, input [`SB_WIDTH-1:0] sb, input int n, input [31:0] base, input slow);
      reg [127:0] w;
      reg [3:0] k;
      int i;
      int j;
      beat(d, 4'hf, n == 0, sb);
      for (i = 0; i < n; i += 4) begin
         for (j = 0; j < 4; j++) begin
            w[32*j+:32] = base + i + j;
            k[j] = i + j < n;
         end
         if (slow) begin
            idle;
            @(posedge ref_clk);
         end
         beat(w, k, i + 4 >= n, sb);
      end
      idle;
   endtask
endmodule

// ===== testbench/test_pcie_requester_request_intake.sv
// Testbench for request_intake: APB, request stream, header and payload.
// Assumes client_model and the checker are compiled alongside.
`timescale 1ns/10ps
`include "request_intake_consts.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module test_pcie_requester_request_intake;
   reg ref_clk = 1'b0;
   reg reset = 1'b1;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [7:0] paddr = 8'h00;
   reg [31:0] pwdata = 32'h0;
   reg hdr_ready = 1'b0;
   reg pay_ready = 1'b0;
   wire [31:0] prdata, pay_data;
   wire [127:0] req_tdata;
   wire [3:0] req_tkeep, hdr_request_type, head_dword_byte_enables, tail_dword_byte_enables;
   wire [`SB_WIDTH-1:0] request_sideband_bus;
   wire [2:0] hdr_layout;
   wire [1:0] hdr_address_type, hint_steering_kind;
   wire [63:2] hdr_address;
   wire [10:0] hdr_dword_count;
   wire [7:0] hint_steering_value;
   wire pready, pslverr, req_tvalid, req_tlast, req_tready, hdr_valid, hdr_hint_present, pay_valid, pay_last;
   int bad_count = 0;
   int num_checks = 0;
   int cycles = 0;
   reg [32:0] pay_q[$];
   initial forever #20 ref_clk = ~ref_clk;
   request_intake #(.DATA_WIDTH(128), .payload_alignment_select(0)) dut_u (.ref_clk(ref_clk), .reset(reset),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .req_tdata(req_tdata), .req_tkeep(req_tkeep),
      .req_tvalid(req_tvalid), .req_tlast(req_tlast), .req_tready(req_tready),
      .request_sideband_bus(request_sideband_bus), .hdr_valid(hdr_valid), .hdr_ready(hdr_ready),
      .hdr_layout(hdr_layout), .hdr_request_type(hdr_request_type), .hdr_address_type(hdr_address_type),
      .hdr_address(hdr_address), .hdr_dword_count(hdr_dword_count),
      .head_dword_byte_enables(head_dword_byte_enables), .tail_dword_byte_enables(tail_dword_byte_enables),
      .hdr_hint_present(hdr_hint_present), .hint_steering_value(hint_steering_value),
      .hint_steering_kind(hint_steering_kind), .pay_valid(pay_valid), .pay_ready(pay_ready),
      .pay_data(pay_data), .pay_last(pay_last));
   client_model client_u (.ref_clk(ref_clk), .req_tready(req_tready), .req_tdata(req_tdata),
      .req_tkeep(req_tkeep), .req_tvalid(req_tvalid), .req_tlast(req_tlast),
      .request_sideband_bus(request_sideband_bus));
   always @(posedge ref_clk) begin
      if (pay_valid === 1'b1 && pay_ready === 1'b1) pay_q.push_back({pay_last, pay_data});
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         stop_test;
      end
   end
   function [127:0] desc(input [3:0] t, input [10:0] c, input [63:2] a, input [1:0] at);
      desc = {49'h0, t, c, a, at};
   endfunction
   function [`SB_WIDTH-1:0] sbus(input [3:0] hb, input [3:0] tb, input ind, input hp, input [7:0] st,
      input [1:0] sk);
      sbus = {sk, st, ind, hp, 3'h0, tb, hb};
   endfunction
   function [2:0] lay(input [3:0] t);
      lay = t < 4'h8 ? `LAYOUT_MEM_IO_ATOMIC : t < 4'hc ? `LAYOUT_CONFIG : t == `REQ_MESSAGE ?
         `LAYOUT_OTHER_MSG : t == `REQ_VENDOR_MESSAGE ? `LAYOUT_VENDOR : `LAYOUT_ATS;
   endfunction
   task apb(input wr, input [7:0] a, input [31:0] d, output [31:0] r, output e);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task hdr_chk(input [2:0] ly, input [1:0] at, input [63:2] ad, input [10:0] c, input [3:0] hb,
      input [3:0] tb, input hp, input [7:0] hv, input [1:0] hk);
      int n;
      n = 0;
      while (hdr_valid !== 1'b1 && n < 100) begin
         @(posedge ref_clk);
         n++;
      end
      `CHK(hdr_valid, 1'b1)
      `CHK(hdr_layout, ly)
      `CHK(hdr_address_type, at)
      `CHK(hdr_address, ad)
      `CHK(hdr_dword_count, c)
      `CHK({tail_dword_byte_enables, head_dword_byte_enables}, {tb, hb})
      `CHK(hdr_hint_present, hp)
      if (hp) `CHK({hint_steering_value, hint_steering_kind}, {hv, hk})
      hdr_ready <= 1'b1;
      @(posedge ref_clk);
      hdr_ready <= 1'b0;
      @(posedge ref_clk);
   endtask
   task t_regs;
      reg [31:0] r;
      reg e;
      apb(1'b0, `OFS_CONTROL, 32'h0, r, e);
      `CHK(r, 32'h0)
      apb(1'b0, `OFS_PACKET_COUNT, 32'h0, r, e);
      `CHK(r, 32'h0)
      apb(1'b1, `OFS_TABLE_INDEX, 32'h5, r, e);
      apb(1'b1, `OFS_TABLE_DATA, 32'h3c, r, e);
      apb(1'b0, `OFS_TABLE_DATA, 32'h0, r, e);
      `CHK(r[7:0], 8'h3c)
      apb(1'b1, `OFS_CONTROL, 32'h1, r, e);
      apb(1'b0, `OFS_CONTROL, 32'h0, r, e);
      `CHK(r[0], 1'b1)
      apb(1'b0, 8'h40, 32'h0, r, e);
      `CHK({e, r}, {1'b1, 32'h0})
   endtask
   // Every request kind, header only, zero-length count of one
   task t_kinds;
      int k;
      for (k = 0; k < 15; k++) begin
         fork
            client_u.send(desc(k, 11'd1, 62'h40, 2'h1), sbus(4'h0, 4'h0, 0, k == 0, 8'h5a, 2'h2), 0, 0, 0);
            hdr_chk(lay(k), (k < 8 && k != 2 && k != 3) ? 2'h1 : 2'h0, k < 8 ? 62'h40 : 62'h0, 11'd1, 4'h0,
               4'h0, k == 0, 8'h5a, 2'h2);
         join
         `CHK(hdr_request_type, k[3:0])
      end
   endtask
   task t_indirect;
      reg [31:0] r;
      reg e;
      fork
         client_u.send(desc(`REQ_MEM_READ, 11'd4, 62'h80, 2'h0), sbus(4'hf, 4'hf, 1, 1, 8'h05, 2'h1), 0, 0, 0);
         hdr_chk(`LAYOUT_MEM_IO_ATOMIC, 2'h0, 62'h80, 11'd4, 4'hf, 4'hf, 1, 8'h3c, 2'h1);
      join
      apb(1'b1, `OFS_CONTROL, 32'h0, r, e);
      fork
         client_u.send(desc(`REQ_MEM_READ, 11'd4, 62'h80, 2'h0), sbus(4'hf, 4'hf, 0, 1, 8'h77, 2'h1), 0, 0, 0);
         hdr_chk(`LAYOUT_MEM_IO_ATOMIC, 2'h0, 62'h80, 11'd4, 4'hf, 4'hf, 0, 8'h0, 2'h0);
      join
   endtask
   // Count of three with ten words: nothing trims it; FIFO fills meanwhile
   task t_stall;
      int i;
      fork
         client_u.send(desc(`REQ_MEM_WRITE, 11'd3, 62'h1234_5678_9abc_def, 2'h2), sbus(4'hf, 4'h3, 0, 0, 8'h0,
            2'h0), 10, 32'ha000, 1);
         hdr_chk(`LAYOUT_MEM_IO_ATOMIC, 2'h2, 62'h1234_5678_9abc_def, 11'd3, 4'hf, 4'h3, 0, 8'h0, 2'h0);
         begin
            repeat (40) @(posedge ref_clk);
            `CHK({req_tready, pay_valid}, 2'b01)
            pay_ready <= 1'b1;
         end
      join
      repeat (30) @(posedge ref_clk);
      `CHK(pay_q.size(), 10)
      for (i = 0; i < 10 && pay_q.size() > 0; i++) `CHK(pay_q.pop_front(), {i == 9, 32'ha000 + i})
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      t_regs;
      t_kinds;
      t_indirect;
      t_stall;
      stop_test;
   end
endmodule
